// ==== verification/dbg_override_ctrl_bench.sv ====
// Self-checking bench for the debug override register bank
`default_nettype none
module dbg_override_ctrl_bench;
  import dbg_override_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, dmiss = 0, imiss = 0, mmu = 0, dc = 0, rv = 0, st = 0;
  logic nc = 0, sq = 0, hit, pf;
  logic [31:0] rdata, taddr;
  cp_req_t req = '0;
  attr_t ra = '0, pa = '0, da;
  ovr_ctrl_t ovr;
  miss_resp_t dr, ir;
  int n_errors = 0, n_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  dbg_override_ctrl i_dbg_override_ctrl (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CP_REQ_I(req),
    .CP_RDATA_O(rdata), .CP_HIT_O(hit), .OVR_CTRL_O(ovr), .TEST_ADDR_O(taddr),
    .DATA_TRANSLATION_CACHE_MISS_I(dmiss), .INSTRUCTION_TRANSLATION_CACHE_MISS_I(imiss), .DATA_TRANSLATION_CACHE_RESP_O(dr), .INSTRUCTION_TRANSLATION_CACHE_RESP_O(ir),
    .MMU_EN_I(mmu), .DATA_CACHE_EN_I(dc), .REMAP_VALID_I(rv), .REMAP_ATTR_I(ra),
    .PAGE_ATTR_I(pa), .STORE_I(st), .DATA_ATTR_O(da), .NC_FETCH_I(nc),
    .SEQ_PREFETCH_I(sq), .PREFETCH_EN_O(pf));
  // Hang guard: the run needs about sixty cycles
  always @(posedge clk) if (++cyc == 1000) begin n_errors++; close_out(); end
  task automatic close_out();
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One access, then an idle cycle so the override outputs have settled
  task automatic cp(input logic wr, input logic [3:0] crm, input logic [2:0] op1,
    input logic [31:0] wd, input logic [31:0] e);
    req = {1'b1, wr, 4'hF, op1, 4'hF, crm, 3'h0, wd};
    @(posedge clk) #1;
    chk({31'h0, hit}, {31'h0, op1 == 3'h0});
    if (!wr) chk(rdata, e);
    req.valid = 1'b0;
    @(posedge clk) #1;
  endtask : cp
  // One cycle of the miss, prefetch and attribute paths
  task automatic step(input logic [31:0] e_miss, input logic [31:0] e_pf, e_da);
    @(posedge clk) #1;
    chk(32'(dr), e_miss);
    chk(32'(ir), e_miss);
    chk({31'h0, pf}, e_pf);
    chk(32'(da), e_da);
  endtask : step
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1;
    chk(32'(ovr), 32'h0);
    cp(0, 0, 0, 0, 32'h0);
    cp(0, 1, 0, 0, 32'h0);
    for (int b = 13; b < 20; b++) begin
      cp(1, 0, 0, (32'h1 << b) | 32'hFFF01FFF, 0);
      chk(32'(ovr), 32'h1 << (b - 13));
      cp(0, 0, 0, 0, 32'h1 << b);
    end
    cp(1, 0, 0, 32'hFFFFFFFF, 0);
    cp(0, 0, 0, 0, 32'h000FE000);
    cp(1, 0, 3'h1, 32'h0, 0);
    chk(32'(ovr), 32'h7F);
    cp(1, 1, 0, 32'hA5A55A5A, 0);
    chk(taddr, 32'hA5A55A5A);
    cp(0, 1, 0, 0, 32'hA5A55A5A);
    {dmiss, imiss, nc, sq, st, mmu} = 6'h3F;
    pa = 2'h1;
    step(32'h20, 0, 0);
    cp(1, 0, 0, 32'h0, 0);
    step(32'h10, 1, 1);
    {st, mmu, dc} = 3'h1;
    cp(1, 0, 0, 32'h2000, 0);
    step(32'h10, 1, 2);
    rv = 1;
    step(32'h10, 1, 0);
    cp(1, 0, 0, 32'h4000, 0);
    {st, mmu} = 2'h3;
    ra = 2'h1;
    step(32'h10, 1, 0);
    close_out();
  end
endmodule : dbg_override_ctrl_bench
`default_nettype wire

// ==== verification/dbg_override_ctrl_monitor.sv ====
// Checker for the debug override register bank
`include "dbg_override_cfg.svh"
`default_nettype none
module dbg_override_monitor
  import dbg_override_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire cp_req_t CP_REQ_I,
  input wire logic [31:0] CP_RDATA_O,
  input wire logic CP_HIT_O,
  input wire ovr_ctrl_t OVR_CTRL_O,
  input wire logic DATA_TRANSLATION_CACHE_MISS_I,
  input wire logic INSTRUCTION_TRANSLATION_CACHE_MISS_I,
  input wire miss_resp_t DATA_TRANSLATION_CACHE_RESP_O,
  input wire miss_resp_t INSTRUCTION_TRANSLATION_CACHE_RESP_O,
  input wire logic MMU_EN_I,
  input wire logic DATA_CACHE_EN_I,
  input wire logic REMAP_VALID_I,
  input wire attr_t REMAP_ATTR_I,
  input wire attr_t PAGE_ATTR_I,
  input wire logic STORE_I,
  input wire attr_t DATA_ATTR_O,
  input wire logic NC_FETCH_I,
  input wire logic SEQ_PREFETCH_I,
  input wire logic PREFETCH_EN_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Accepted access to either register of the bank
  logic take;
  assign take = CP_REQ_I.valid && CP_REQ_I.cp_num == `CP_NUM && CP_REQ_I.op1 == `CP_OP1
    && CP_REQ_I.crn == `CP_CRN && CP_REQ_I.op2 == `CP_OP2 && CP_REQ_I.crm[3:1] == 3'h0;
  sequence s_wr0; take && CP_REQ_I.write && CP_REQ_I.crm == `CP_CRM_OVR; endsequence
  sequence s_rd0; take && !CP_REQ_I.write && CP_REQ_I.crm == `CP_CRM_OVR; endsequence
  property p_hit; 1'b1 |=> CP_HIT_O == $past(take); endproperty
  property p_wr; s_wr0 |=> ##1 OVR_CTRL_O == $past(CP_REQ_I.wdata[19:13], 2); endproperty
  property p_rd; s_rd0 |=> CP_RDATA_O == {12'h000, OVR_CTRL_O, 13'h0000}; endproperty
  property p_data_translation_cache; 1'b1 |=> DATA_TRANSLATION_CACHE_RESP_O == {$past(DATA_TRANSLATION_CACHE_MISS_I) & OVR_CTRL_O.abort_data_translation_cache,
    $past(DATA_TRANSLATION_CACHE_MISS_I) & !OVR_CTRL_O.abort_data_translation_cache, 4'h0}; endproperty
  property p_instruction_translation_cache; 1'b1 |=> INSTRUCTION_TRANSLATION_CACHE_RESP_O == {$past(INSTRUCTION_TRANSLATION_CACHE_MISS_I) & OVR_CTRL_O.abort_instruction_translation_cache,
    $past(INSTRUCTION_TRANSLATION_CACHE_MISS_I) & !OVR_CTRL_O.abort_instruction_translation_cache, 4'h0}; endproperty
  property p_pref; 1'b1 |=> PREFETCH_EN_O ==
    ($past(SEQ_PREFETCH_I) & !($past(NC_FETCH_I) & OVR_CTRL_O.no_nc_prefetch)); endproperty
  property p_store; STORE_I && MMU_EN_I && (REMAP_VALID_I ? REMAP_ATTR_I : PAGE_ATTR_I) == 2'h1
    |=> DATA_ATTR_O == (OVR_CTRL_O.force_noncacheable_nonbufferable ? 2'h0 : 2'h1); endproperty
  property p_wt; !MMU_EN_I && DATA_CACHE_EN_I && !REMAP_VALID_I
    |=> DATA_ATTR_O == {OVR_CTRL_O.wt_nommu, 1'b0}; endproperty
  a_hit: assert property (p_hit) else $error("hit flag wrong");
  a_wr: assert property (p_wr) else $error("override bits not taken");
  a_rd: assert property (p_rd) else $error("override read wrong");
  a_data_translation_cache: assert property (p_data_translation_cache) else $error("data miss response wrong");
  a_instruction_translation_cache: assert property (p_instruction_translation_cache) else $error("instr miss response wrong");
  a_pref: assert property (p_pref) else $error("prefetch enable wrong");
  a_store: assert property (p_store) else $error("store forcing wrong");
  a_wt: assert property (p_wt) else $error("translation-off attribute wrong");
endmodule : dbg_override_monitor
bind dbg_override_ctrl dbg_override_monitor i_dbg_override_monitor (.*);
`default_nettype wire

// ==== verilog/dbg_override_cfg.svh ====
// Constants for the debug override register bank
`ifndef DBG_OVERRIDE_CFG_SVH
`define DBG_OVERRIDE_CFG_SVH
// ==========================================================
// Coprocessor access decode
`define CP_NUM 4'hF
`define CP_OP1 3'h0
`define CP_CRN 4'hF
`define CP_CRM_OVR 4'h0
`define CP_CRM_ADDR 4'h1
`define CP_OP2 3'h0
// ==========================================================
// Field positions of the override register
`define OVR_CLEAN_ALL_BIT 19
`define OVR_ABORT_D_BIT 18
`define OVR_ABORT_I_BIT 17
`define OVR_NO_PREFETCH_BIT 16
`define OVR_NO_CLKGATE_BIT 15
`define OVR_FORCE_NONCACHEABLE_NONBUFFERABLE_BIT 14
`define OVR_WT_NOMMU_BIT 13
`define OVR_WRITE_MASK 32'h000FE000
// ==========================================================
// Reset values and fault status code
`define OVR_RESET 32'h00000000
`define ADDR_RESET 32'h00000000
`define FAULT_TRANSLATION 4'h0
`endif

// ==== verilog/dbg_override_ctrl.sv ====
// Debug override and debug/test address register bank
`include "dbg_override_cfg.svh"
`default_nettype none
module dbg_override_ctrl
  import dbg_override_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire cp_req_t CP_REQ_I,
  output logic [31:0] CP_RDATA_O,
  output logic CP_HIT_O,
  output ovr_ctrl_t OVR_CTRL_O,
  output logic [31:0] TEST_ADDR_O,
  input wire logic DATA_TRANSLATION_CACHE_MISS_I,
  input wire logic INSTRUCTION_TRANSLATION_CACHE_MISS_I,
  output miss_resp_t DATA_TRANSLATION_CACHE_RESP_O,
  output miss_resp_t INSTRUCTION_TRANSLATION_CACHE_RESP_O,
  input wire logic MMU_EN_I,
  input wire logic DATA_CACHE_EN_I,
  input wire logic REMAP_VALID_I,
  input wire attr_t REMAP_ATTR_I,
  input wire attr_t PAGE_ATTR_I,
  input wire logic STORE_I,
  output attr_t DATA_ATTR_O,
  input wire logic NC_FETCH_I,
  input wire logic SEQ_PREFETCH_I,
  output logic PREFETCH_EN_O
);

  // ========================================================
  // Decode
  // Every access is a single-cycle pulse on CP_REQ_I.valid, so the
  // decode is purely combinational and needs no handshake state.
  // Encodings outside the two registers of this bank are ignored
  // here; other banks of the coprocessor answer for them.
  // Matches a coprocessor access against one secondary register
  function automatic logic cp_match(input cp_req_t r, input logic [3:0] crm);
    cp_match = r.valid && (r.cp_num == `CP_NUM) && (r.op1 == `CP_OP1) &&
               (r.crn == `CP_CRN) && (r.crm == crm) && (r.op2 == `CP_OP2);
  endfunction : cp_match

  // Decoded hits, valid only while the request pulse stands
  logic hit_ovr; // Access to the override register
  logic hit_addr; // Access to the address register
  logic [31:0] ovr_reg; // Override bits
  logic [31:0] addr_reg; // Debug and test address

  assign hit_ovr = cp_match(CP_REQ_I, `CP_CRM_OVR);
  assign hit_addr = cp_match(CP_REQ_I, `CP_CRM_ADDR);

  // ========================================================
  // Registers
  // Only the seven defined bits are stored. Keeping the reserved bits
  // as constant zero saves flops and makes reads predictable, which
  // software must not rely on anyway.
  // Override register; reserved bits are dropped so reads give zero
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ovr_reg <= `OVR_RESET;
    end else if (hit_ovr && CP_REQ_I.write) begin
      ovr_reg <= CP_REQ_I.wdata & `OVR_WRITE_MASK;
    end
  end

  // Address register, full width
  // Used by debug, test and translation test operations; every bit
  // is kept because the entry-select fields span the whole word.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      addr_reg <= `ADDR_RESET;
    end else if (hit_addr && CP_REQ_I.write) begin
      addr_reg <= CP_REQ_I.wdata;
    end
  end

  // Read data registered one cycle after the read access
  // The answer stands for exactly one cycle; a write or an access
  // outside the bank returns zero so the core never sees stale data.
  // The hit flag is raised for reads and writes alike.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CP_RDATA_O <= 32'h00000000;
      CP_HIT_O <= 1'b0;
    end else begin
      CP_HIT_O <= hit_ovr || hit_addr;
      if (hit_ovr && !CP_REQ_I.write) begin
        CP_RDATA_O <= ovr_reg;
      end else if (hit_addr && !CP_REQ_I.write) begin
        CP_RDATA_O <= addr_reg;
      end else begin
        CP_RDATA_O <= 32'h00000000; // Writes and misses answer zero
      end
    end
  end

  // ========================================================
  // Control outputs
  // The memory system reads these as ordinary flops, which keeps the
  // override paths free of the coprocessor decode timing.
  // Registered copy of the bits; one cycle after the write so the
  // instruction has retired before any later access sees them
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      OVR_CTRL_O <= '0;
      TEST_ADDR_O <= 32'h00000000;
    end else begin
      OVR_CTRL_O.clean_all <= ovr_reg[`OVR_CLEAN_ALL_BIT];
      OVR_CTRL_O.abort_data_translation_cache <= ovr_reg[`OVR_ABORT_D_BIT];
      OVR_CTRL_O.abort_instruction_translation_cache <= ovr_reg[`OVR_ABORT_I_BIT];
      OVR_CTRL_O.no_nc_prefetch <= ovr_reg[`OVR_NO_PREFETCH_BIT];
      // Only gates clocks; no datapath reads it
      OVR_CTRL_O.no_clk_gate <= ovr_reg[`OVR_NO_CLKGATE_BIT];
      OVR_CTRL_O.force_noncacheable_nonbufferable <= ovr_reg[`OVR_FORCE_NONCACHEABLE_NONBUFFERABLE_BIT];
      OVR_CTRL_O.wt_nommu <= ovr_reg[`OVR_WT_NOMMU_BIT];
      TEST_ADDR_O <= addr_reg;
    end
  end

  // ========================================================
  // Translation cache miss handling
  // Abort means translation fault and no table walk
  // Walk and abort are mutually exclusive by construction: a miss
  // either starts a walk or is aborted, never both.
  // The status code is held constant; the fault status register
  // outside this bank latches it only when abort is high.
  // The abort bits are read straight from the register, so the
  // first miss after the write already obeys the new setting.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      DATA_TRANSLATION_CACHE_RESP_O <= '0;
      INSTRUCTION_TRANSLATION_CACHE_RESP_O <= '0;
    end else begin
      DATA_TRANSLATION_CACHE_RESP_O.abort <= DATA_TRANSLATION_CACHE_MISS_I && ovr_reg[`OVR_ABORT_D_BIT];
      DATA_TRANSLATION_CACHE_RESP_O.walk <= DATA_TRANSLATION_CACHE_MISS_I && !ovr_reg[`OVR_ABORT_D_BIT];
      DATA_TRANSLATION_CACHE_RESP_O.status <= `FAULT_TRANSLATION;
      INSTRUCTION_TRANSLATION_CACHE_RESP_O.abort <= INSTRUCTION_TRANSLATION_CACHE_MISS_I && ovr_reg[`OVR_ABORT_I_BIT];
      INSTRUCTION_TRANSLATION_CACHE_RESP_O.walk <= INSTRUCTION_TRANSLATION_CACHE_MISS_I && !ovr_reg[`OVR_ABORT_I_BIT];
      INSTRUCTION_TRANSLATION_CACHE_RESP_O.status <= `FAULT_TRANSLATION;
    end
  end

  // ========================================================
  // Instruction prefetch
  // Demand fetches never pass here; only speculative ones are gated
  // With the bit clear every sequential prefetch request goes out;
  // with it set only cacheable-region prefetches survive.
  // Limitation: the noncacheable flag must be valid in the same cycle
  // as the prefetch request, or a prefetch may slip through.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PREFETCH_EN_O <= 1'b0;
    end else begin
      PREFETCH_EN_O <= SEQ_PREFETCH_I &&
                       !(NC_FETCH_I && ovr_reg[`OVR_NO_PREFETCH_BIT]);
    end
  end

  // ========================================================
  // Data attributes
  attr_t attr_next; // Resolved level one attributes
  // Priority: store forcing, then remap, then bit 13, then page tables
  // Write-through is encoded as cacheable and not bufferable.
  // Store forcing is applied last so that it beats both the page
  // tables and the remap setting, as software expects.
  // Loads are never forced; only bufferable noncacheable stores are.
  always_comb begin
    if (!MMU_EN_I) begin
      attr_next = '0; // Default noncacheable nonbufferable
      if (ovr_reg[`OVR_WT_NOMMU_BIT] && DATA_CACHE_EN_I) begin
        attr_next = '{cacheable: 1'b1, bufferable: 1'b0};
      end
    end else begin
      attr_next = PAGE_ATTR_I;
    end
    if (REMAP_VALID_I) begin
      attr_next = REMAP_ATTR_I;
    end
    if (STORE_I && ovr_reg[`OVR_FORCE_NONCACHEABLE_NONBUFFERABLE_BIT] && !attr_next.cacheable &&
        attr_next.bufferable) begin
      attr_next.bufferable = 1'b0;
    end
  end

  // Registered attribute output
  // One cycle of latency; the level one pipeline samples it with the
  // access that produced the inputs one cycle earlier.
  // Registering here keeps the top-level outputs flop-driven and
  // hides the priority chain from downstream timing.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      DATA_ATTR_O <= '0;
    end else begin
      DATA_ATTR_O <= attr_next;
    end
  end

endmodule : dbg_override_ctrl
`default_nettype wire

// ==== verilog/dbg_override_pkg.sv ====
// Types shared by the debug override register bank
`default_nettype none
package dbg_override_pkg;
  // Coprocessor register access from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] cp_num;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    logic [31:0] wdata;
  } cp_req_t;
  // Memory-system overrides derived from the register
  typedef struct packed {
    logic clean_all;
    logic abort_data_translation_cache;
    logic abort_instruction_translation_cache;
    logic no_nc_prefetch;
    logic no_clk_gate;
    logic force_noncacheable_nonbufferable;
    logic wt_nommu;
  } ovr_ctrl_t;
  // Translation cache miss report
  typedef struct packed {
    logic abort;
    logic walk;
    logic [3:0] status;
  } miss_resp_t;
  // Level one data attributes
  typedef struct packed {
    logic cacheable;
    logic bufferable;
  } attr_t;
endpackage : dbg_override_pkg
`default_nettype wire
